//--- rtl/dcfm_pkg.sv
// Shared constants, port strobe record and decode helper for the FIFO/mailbox controller.
package dcfm_pkg;

  // ------------------------------------------------------------------
  // Geometry
  // ------------------------------------------------------------------
  localparam int DATA_W_DEF = 36;
  localparam int DEPTH_DEF = 2048;
  localparam int OFF_W = 11;

  // ------------------------------------------------------------------
  // Offset programming
  // ------------------------------------------------------------------
  localparam logic [4:0] SER_LAST = 5'h15;
  localparam logic [10:0] PRESET_LO = 11'h008;
  localparam logic [10:0] PRESET_HI = 11'h040;
  localparam logic [10:0] OFF_RST = 11'h000;
  localparam logic [1:0] METH_PARALLEL = 2'h0;
  localparam logic [1:0] METH_PRESET_LO = 2'h1;
  localparam logic [1:0] METH_PRESET_HI = 2'h2;
  localparam logic [1:0] METH_SERIAL = 2'h3;

  // ------------------------------------------------------------------
  // Timing and reset values
  // ------------------------------------------------------------------
  localparam logic [1:0] IR_DELAY = 2'h2;
  localparam logic IR_RST = 1'b0;
  localparam logic OR_RST = 1'b0;
  localparam logic AE_RST = 1'b0;
  localparam logic AF_RST = 1'b1;
  localparam logic MBF_RST = 1'b1;

  typedef enum {PRG_CAPTURE, PRG_SERIAL, PRG_PARALLEL, PRG_RUN} dcfm_prog_type;

  typedef struct packed {
    logic sel_n;
    logic gate;
    logic write;
    logic mbox;
  } dcfm_port_type;

  // A port access counts on its clock edge only when selected and gated; side B's fall-through load and replay from the mark need neither.
  function automatic logic dcfm_go(input dcfm_port_type p);
    return !p.sel_n && p.gate;
  endfunction

endpackage

//--- rtl/dcfm_ctl.sv
// Controller for a 36-bit FIFO from side A to side B with a mailbox each way.
`timescale 1ns/100ps

module dcfm_ctl
  import dcfm_pkg::*;
#(
  parameter int DATA_W = DATA_W_DEF,
  parameter int DEPTH = DEPTH_DEF
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic side_a_clock_i,
  input wire logic side_a_select_n_i,
  input wire logic side_a_gate_i,
  input wire logic side_a_direction_i,
  input wire logic side_a_mailbox_sel_i,
  input wire logic [DATA_W-1:0] a_data_i,
  output logic [DATA_W-1:0] a_data_o,
  output logic a_data_oe_o,
  input wire logic side_b_clock_i,
  input wire logic side_b_select_n_i,
  input wire logic side_b_gate_i,
  input wire logic side_b_read_i,
  input wire logic side_b_mailbox_sel_i,
  input wire logic [DATA_W-1:0] b_data_i,
  output logic [DATA_W-1:0] b_data_o,
  output logic b_data_oe_o,
  input wire logic offset_method_hi_serial_gate_i,
  input wire logic offset_method_lo_serial_bit_i,
  input wire logic replay_mode_sel_i,
  input wire logic replay_from_mark_i,
  output logic input_room_flag_o,
  output logic output_valid_flag_o,
  output logic near_empty_flag_n_o,
  output logic near_full_flag_n_o,
  output logic mail1_full_n_o,
  output logic mail2_full_n_o
);

  localparam int AW = $clog2(DEPTH);
  localparam int PW = AW + 1;
  localparam logic [PW-1:0] DEPTH_P = PW'(DEPTH);

  // ------------------------------------------------------------------
  // Reset release and clock edges
  // ------------------------------------------------------------------
  logic [1:0] rst_sync_r;
  logic rst_n;
  logic a_clk_r;
  logic b_clk_r;
  logic a_edge;
  logic b_edge;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      // Starting high keeps a port clock that is high at release from reading as an edge.
      a_clk_r <= 1'b1;
      b_clk_r <= 1'b1;
    end else if (ce_i) begin
      a_clk_r <= side_a_clock_i;
      b_clk_r <= side_b_clock_i;
    end
  end
  assign a_edge = ce_i && side_a_clock_i && !a_clk_r;
  assign b_edge = ce_i && side_b_clock_i && !b_clk_r;

  // ------------------------------------------------------------------
  // Port decode
  // ------------------------------------------------------------------
  dcfm_port_type a_port;
  dcfm_port_type b_port;
  logic a_go;
  logic b_go;
  logic ir_r;
  logic or_r;
  logic a_fifo_wr;
  logic mem_wr;
  logic a_mail1_wr;
  logic a_mail2_rd;
  logic b_fifo_rd;
  logic b_mail1_rd;
  logic b_mail2_wr;
  dcfm_prog_type prog_r;

  assign a_port = '{sel_n: side_a_select_n_i, gate: side_a_gate_i,
                    write: side_a_direction_i, mbox: side_a_mailbox_sel_i};
  assign b_port = '{sel_n: side_b_select_n_i, gate: side_b_gate_i,
                    write: !side_b_read_i, mbox: side_b_mailbox_sel_i};
  assign a_go = a_edge && dcfm_go(a_port);
  assign b_go = b_edge && dcfm_go(b_port);
  assign a_fifo_wr = a_go && a_port.write && !a_port.mbox && ir_r;
  assign mem_wr = a_fifo_wr && (prog_r == PRG_RUN);
  assign a_mail1_wr = a_go && a_port.write && a_port.mbox;
  assign a_mail2_rd = a_go && !a_port.write && a_port.mbox;
  assign b_fifo_rd = b_go && !b_port.write && !b_port.mbox && or_r;
  assign b_mail1_rd = b_go && !b_port.write && b_port.mbox;
  assign b_mail2_wr = b_go && b_port.write && b_port.mbox;

  // ------------------------------------------------------------------
  // Offset programming
  // ------------------------------------------------------------------
  logic [OFF_W-1:0] x_r;
  logic [OFF_W-1:0] y_r;
  logic [4:0] ser_cnt_r;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      prog_r <= PRG_CAPTURE;
      x_r <= OFF_RST;
      y_r <= OFF_RST;
      ser_cnt_r <= 5'h00;
    end else if (ce_i) begin
      case (prog_r)
        PRG_CAPTURE: begin
          case ({offset_method_hi_serial_gate_i, offset_method_lo_serial_bit_i})
            METH_SERIAL: prog_r <= PRG_SERIAL;
            METH_PARALLEL: prog_r <= PRG_PARALLEL;
            METH_PRESET_LO: begin
              x_r <= PRESET_LO;
              y_r <= PRESET_LO;
              prog_r <= PRG_RUN;
            end
            default: begin
              x_r <= PRESET_HI;
              y_r <= PRESET_HI;
              prog_r <= PRG_RUN;
            end
          endcase
        end
        PRG_SERIAL: begin
          if (a_edge && !offset_method_hi_serial_gate_i) begin
            {y_r, x_r} <= {y_r[OFF_W-2:0], x_r, offset_method_lo_serial_bit_i};
            ser_cnt_r <= ser_cnt_r + 5'h01;
            if (ser_cnt_r == SER_LAST) begin
              prog_r <= PRG_RUN;
            end
          end
        end
        PRG_PARALLEL: begin
          if (a_fifo_wr) begin
            if (ser_cnt_r == 5'h00) begin
              y_r <= a_data_i[OFF_W-1:0];
              ser_cnt_r <= 5'h01;
            end else begin
              x_r <= a_data_i[OFF_W-1:0];
              prog_r <= PRG_RUN;
            end
          end
        end
        PRG_RUN: prog_r <= PRG_RUN;
        default: prog_r <= PRG_CAPTURE;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Memory and write side
  // ------------------------------------------------------------------
  logic [DATA_W-1:0] mem [DEPTH];
  logic [PW-1:0] wptr_r;
  logic [PW-1:0] wptr_nxt;

  always_ff @(posedge clk_i) begin
    if (ce_i && mem_wr) begin
      mem[wptr_r[AW-1:0]] <= a_data_i;
    end
  end

  assign wptr_nxt = wptr_r + PW'(mem_wr);

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wptr_r <= '0;
    end else begin
      wptr_r <= wptr_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Pointer transfer between the two sides
  // ------------------------------------------------------------------
  logic [PW-1:0] rptr_r;
  logic [PW-1:0] mark_r;
  logic retx_r;
  logic [1:0][PW-1:0] wsync_r;
  logic [1:0][PW-1:0] rsync_r;
  logic [1:0][PW-1:0] msync_r;
  logic [1:0] xsync_r;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wsync_r <= '0;
    end else if (b_edge) begin
      wsync_r <= {wsync_r[0], wptr_r};
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rsync_r <= '0;
      msync_r <= '0;
      xsync_r <= 2'h0;
    end else if (a_edge) begin
      rsync_r <= {rsync_r[0], rptr_r};
      msync_r <= {msync_r[0], mark_r};
      xsync_r <= {xsync_r[0], retx_r};
    end
  end

  // ------------------------------------------------------------------
  // Side-A flags
  // ------------------------------------------------------------------
  logic [1:0] ir_dly_r;
  logic af_r;
  logic [PW-1:0] base_a;
  logic [PW-1:0] used_a;
  logic [PW-1:0] free_a;

  assign base_a = xsync_r[1] ? msync_r[1] : rsync_r[1];
  assign used_a = wptr_nxt - base_a;
  assign free_a = DEPTH_P - used_a;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ir_r <= IR_RST;
      ir_dly_r <= 2'h0;
      af_r <= AF_RST;
    end else if (a_edge) begin
      if (ir_dly_r != IR_DELAY) begin
        ir_dly_r <= ir_dly_r + 2'h1;
      end
      if (prog_r == PRG_CAPTURE || prog_r == PRG_SERIAL || ir_dly_r != IR_DELAY) begin
        ir_r <= IR_RST;
      end else begin
        ir_r <= (used_a < DEPTH_P);
      end
      af_r <= (free_a > {1'b0, y_r});
    end
  end

  // ------------------------------------------------------------------
  // Read side and retransmit
  // ------------------------------------------------------------------
  logic [DATA_W-1:0] out_r;
  logic ae_r;
  logic [PW-1:0] used_b;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rptr_r <= '0;
      or_r <= OR_RST;
      out_r <= '0;
    end else if (b_edge) begin
      if (retx_r && replay_from_mark_i) begin
        out_r <= mem[mark_r[AW-1:0]];
        rptr_r <= mark_r + PW'(1);
        or_r <= 1'b1;
      end else if (!or_r || b_fifo_rd) begin
        if (rptr_r != wsync_r[1]) begin
          out_r <= mem[rptr_r[AW-1:0]];
          rptr_r <= rptr_r + PW'(1);
          or_r <= 1'b1;
        end else begin
          or_r <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      retx_r <= 1'b0;
      mark_r <= '0;
    end else if (b_edge) begin
      if (!replay_mode_sel_i) begin
        retx_r <= 1'b0;
      end else if (or_r && !retx_r) begin
        retx_r <= 1'b1;
        mark_r <= rptr_r - PW'(1);
      end
    end
  end

  assign used_b = wsync_r[1] - rptr_r + PW'(or_r);

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ae_r <= AE_RST;
    end else if (b_edge) begin
      ae_r <= (used_b > {1'b0, x_r});
    end
  end

  // ------------------------------------------------------------------
  // Mailboxes
  // ------------------------------------------------------------------
  logic [DATA_W-1:0] mail1_r;
  logic [DATA_W-1:0] mail2_r;
  logic mail1_full_n_r;
  logic mail2_full_n_r;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      mail1_r <= '0;
      mail1_full_n_r <= MBF_RST;
    end else begin
      if (a_mail1_wr) begin
        mail1_r <= a_data_i;
        mail1_full_n_r <= 1'b0;
      end else if (b_mail1_rd) begin
        mail1_full_n_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      mail2_r <= '0;
      mail2_full_n_r <= MBF_RST;
    end else begin
      if (b_mail2_wr) begin
        mail2_r <= b_data_i;
        mail2_full_n_r <= 1'b0;
      end else if (a_mail2_rd) begin
        mail2_full_n_r <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // Output registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      a_data_o <= '0;
      a_data_oe_o <= 1'b0;
      b_data_o <= '0;
      b_data_oe_o <= 1'b0;
    end else if (ce_i) begin
      a_data_o <= mail2_r;
      a_data_oe_o <= !side_a_select_n_i && !side_a_direction_i;
      b_data_o <= side_b_mailbox_sel_i ? mail1_r : out_r;
      b_data_oe_o <= !side_b_select_n_i && side_b_read_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      input_room_flag_o <= IR_RST;
      output_valid_flag_o <= OR_RST;
      near_empty_flag_n_o <= AE_RST;
      near_full_flag_n_o <= AF_RST;
      mail1_full_n_o <= MBF_RST;
      mail2_full_n_o <= MBF_RST;
    end else if (ce_i) begin
      input_room_flag_o <= ir_r;
      output_valid_flag_o <= or_r;
      near_empty_flag_n_o <= ae_r;
      near_full_flag_n_o <= af_r;
      mail1_full_n_o <= mail1_full_n_r;
      mail2_full_n_o <= mail2_full_n_r;
    end
  end

endmodule // dcfm_ctl

//--- testbench/dcfm_port_clk.sv
// Free-running port clocks of the two controllers facing the FIFO.
`timescale 1ns/100ps
module dcfm_port_clk (
  input wire logic clk_i,
  output logic side_a_clock_o,
  output logic side_b_clock_o
);
  logic [1:0] a_cnt_r = 2'h0;
  logic [2:0] b_cnt_r = 3'h0;

  // Both clocks run without pause at unrelated periods of four and five system cycles.
  always_ff @(posedge clk_i) begin
    a_cnt_r <= a_cnt_r + 2'h1;
    b_cnt_r <= (b_cnt_r == 3'h4) ? 3'h0 : b_cnt_r + 3'h1;
  end

  assign side_a_clock_o = a_cnt_r[1];
  assign side_b_clock_o = (b_cnt_r >= 3'h3);
endmodule // dcfm_port_clk

//--- testbench/dcfm_ctl_props.sv
// Port-level assertions for the FIFO and mailbox controller.
`timescale 1ns/100ps
module dcfm_ctl_props (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic side_a_clock_i,
  input wire logic side_a_select_n_i,
  input wire logic side_a_gate_i,
  input wire logic side_a_direction_i,
  input wire logic side_a_mailbox_sel_i,
  input wire logic side_b_clock_i,
  input wire logic side_b_select_n_i,
  input wire logic side_b_gate_i,
  input wire logic side_b_read_i,
  input wire logic side_b_mailbox_sel_i,
  input wire logic a_data_oe_o,
  input wire logic b_data_oe_o,
  input wire logic input_room_flag_o,
  input wire logic output_valid_flag_o,
  input wire logic near_empty_flag_n_o,
  input wire logic mail1_full_n_o,
  input wire logic mail2_full_n_o
);
  logic a_prev_r;
  logic b_prev_r;
  logic a_rise;
  logic b_rise;
  logic a_go;
  logic b_go;

  // Previous clock samples start high so that reset release never looks like an edge.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      a_prev_r <= 1'b1;
      b_prev_r <= 1'b1;
    end else begin
      a_prev_r <= side_a_clock_i;
      b_prev_r <= side_b_clock_i;
    end
  end

  assign a_rise = side_a_clock_i && !a_prev_r;
  assign b_rise = side_b_clock_i && !b_prev_r;
  assign a_go = a_rise && !side_a_select_n_i && side_a_gate_i;
  assign b_go = b_rise && !side_b_select_n_i && side_b_gate_i;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  rst_values_a: assert property (disable iff (1'b0) !resetn_i ##1 !resetn_i |->
    !input_room_flag_o && !output_valid_flag_o && !near_empty_flag_n_o
    && mail1_full_n_o && mail2_full_n_o) else $error("flags wrong during reset");
  mail1_clear_a: assert property (a_go && side_a_direction_i && side_a_mailbox_sel_i
    |-> ##[1:2] !mail1_full_n_o) else $error("mail1 flag not lowered");
  mail1_set_a: assert property (b_go && side_b_read_i && side_b_mailbox_sel_i
    && !(a_go && side_a_direction_i && side_a_mailbox_sel_i)
    |-> ##[1:2] mail1_full_n_o) else $error("mail1 flag not raised");
  mail2_clear_a: assert property (b_go && !side_b_read_i && side_b_mailbox_sel_i
    |-> ##[1:2] !mail2_full_n_o) else $error("mail2 flag not lowered");
  mail2_set_a: assert property (a_go && !side_a_direction_i && side_a_mailbox_sel_i
    && !(b_go && !side_b_read_i && side_b_mailbox_sel_i)
    |-> ##[1:2] mail2_full_n_o) else $error("mail2 flag not raised");
  b_flag_edge_a: assert property ($changed({output_valid_flag_o, near_empty_flag_n_o})
    |-> $past(b_rise, 2)) else $error("side B flag moved off a side B edge");
  room_edge_a: assert property ($changed(input_room_flag_o) |-> $past(a_rise, 2))
    else $error("room flag moved off a side A edge");
  a_drive_a: assert property (a_data_oe_o |->
    $past(!side_a_select_n_i && !side_a_direction_i)) else $error("side A driven wrongly");
  b_drive_a: assert property (b_data_oe_o |->
    $past(!side_b_select_n_i && side_b_read_i)) else $error("side B driven wrongly");

  cover property (a_go && side_a_direction_i && side_a_mailbox_sel_i);
  cover property (b_go && side_b_read_i && !side_b_mailbox_sel_i);
  cover property ($rose(output_valid_flag_o));
endmodule // dcfm_ctl_props

bind dcfm_ctl dcfm_ctl_props u_dcfm_ctl_props (.clk_i(clk_i), .resetn_i(resetn_i),
  .side_a_clock_i(side_a_clock_i), .side_a_select_n_i(side_a_select_n_i),
  .side_a_gate_i(side_a_gate_i), .side_a_direction_i(side_a_direction_i),
  .side_a_mailbox_sel_i(side_a_mailbox_sel_i), .side_b_clock_i(side_b_clock_i),
  .side_b_select_n_i(side_b_select_n_i), .side_b_gate_i(side_b_gate_i),
  .side_b_read_i(side_b_read_i), .side_b_mailbox_sel_i(side_b_mailbox_sel_i),
  .a_data_oe_o(a_data_oe_o), .b_data_oe_o(b_data_oe_o),
  .input_room_flag_o(input_room_flag_o), .output_valid_flag_o(output_valid_flag_o),
  .near_empty_flag_n_o(near_empty_flag_n_o), .mail1_full_n_o(mail1_full_n_o),
  .mail2_full_n_o(mail2_full_n_o));

//--- testbench/tb_dcfm_ctl.sv
// Directed bench for the FIFO and mailbox controller.
`timescale 1ns/100ps
module tb_dcfm_ctl
  import dcfm_pkg::*;
;
  localparam dcfm_port_type IDLE = '{1'b1, 1'b0, 1'b0, 1'b0};
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic a_clk;
  logic b_clk;
  dcfm_port_type pa = IDLE;
  dcfm_port_type pb = IDLE;
  logic [35:0] a_din = 36'h0;
  logic [35:0] b_din = 36'h0;
  logic [35:0] a_dout;
  logic [35:0] b_dout;
  logic [35:0] v;
  logic [35:0] w [0:9];
  logic replay_mode_sel = 1'b0;
  logic replay_from_mark = 1'b0;
  logic fs_hi = 1'b0;
  logic fs_lo = 1'b1;
  logic [21:0] ser_bits = 22'h002002;
  logic room, valid, ne_n, nf_n, m1, m2;
  int fail_count = 0;
  int samples_checked = 0;
  int i;
  // Flag word: near-full, room, valid, near-empty, mail1, mail2 from bit 5 down.
  wire logic [35:0] flg = {30'h0, nf_n, room, valid, ne_n, m1, m2};

  initial forever #50 clk_i = ~clk_i;

  dcfm_port_clk u_dcfm_port_clk (.clk_i(clk_i), .side_a_clock_o(a_clk), .side_b_clock_o(b_clk));

  dcfm_ctl u_dcfm_ctl (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(1'b1),
    .side_a_clock_i(a_clk), .side_a_select_n_i(pa.sel_n), .side_a_gate_i(pa.gate),
    .side_a_direction_i(pa.write), .side_a_mailbox_sel_i(pa.mbox), .a_data_i(a_din),
    .a_data_o(a_dout), .a_data_oe_o(), .side_b_clock_i(b_clk),
    .side_b_select_n_i(pb.sel_n), .side_b_gate_i(pb.gate), .side_b_read_i(!pb.write),
    .side_b_mailbox_sel_i(pb.mbox), .b_data_i(b_din), .b_data_o(b_dout), .b_data_oe_o(),
    .offset_method_hi_serial_gate_i(fs_hi), .offset_method_lo_serial_bit_i(fs_lo),
    .replay_mode_sel_i(replay_mode_sel), .replay_from_mark_i(replay_from_mark), .input_room_flag_o(room),
    .output_valid_flag_o(valid), .near_empty_flag_n_o(ne_n), .near_full_flag_n_o(nf_n),
    .mail1_full_n_o(m1), .mail2_full_n_o(m2));

  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("checked=%0d failed=%0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Returns at the clock edge where the chosen port clock is first seen low again.
  task automatic wait_fall(input logic side_b);
    logic prev;
    logic cur;
    prev = 1'b0;
    for (int n = 0; n < 40; n++) begin
      @(posedge clk_i);
      cur = side_b ? b_clk : a_clk;
      if (prev && !cur) return;
      prev = cur;
    end
    fail_count++;
    complete_run();
  endtask

  task automatic wait_bit(input int k, input logic lvl);
    for (int n = 0; n < 300; n++) begin
      @(posedge clk_i);
      if (flg[k] === lvl) return;
    end
    fail_count++;
    complete_run();
  endtask

  // One access spanning exactly one rising port clock edge; returns the data seen.
  task automatic a_op(input logic gate, wr, mbox, input logic [35:0] din, output logic [35:0] q);
    wait_fall(1'b0);
    pa <= '{1'b0, gate, wr, mbox};
    a_din <= din;
    wait_fall(1'b0);
    q = a_dout;
    pa <= IDLE;
    a_din <= ~din;
  endtask

  task automatic b_op(input logic gate, wr, mbox, input logic [35:0] din, output logic [35:0] q);
    wait_fall(1'b1);
    pb <= '{1'b0, gate, wr, mbox};
    b_din <= din;
    wait_fall(1'b1);
    q = b_dout;
    pb <= IDLE;
    b_din <= ~din;
  endtask

  initial begin
    repeat (20) @(posedge clk_i);
    check(flg, 36'h23);
    resetn_i <= 1'b1;
    wait_bit(4, 1'b1);
    check(flg, 36'h33);
    $display("reset test done");
    a_op(1'b1, 1'b1, 1'b1, 36'h9a5a50f0f, v);
    check(flg, 36'h31);
    b_op(1'b1, 1'b0, 1'b1, 36'h0, v);
    check(v, 36'h9a5a50f0f);
    check(flg, 36'h33);
    b_op(1'b1, 1'b1, 1'b1, 36'h512345678, v);
    check(flg, 36'h32);
    a_op(1'b1, 1'b0, 1'b1, 36'h0, v);
    check(v, 36'h512345678);
    check(flg, 36'h33);
    $display("mailbox test done");
    a_op(1'b0, 1'b1, 1'b0, 36'h111, v);
    repeat (30) @(posedge clk_i);
    check(flg, 36'h33);
    for (i = 0; i < 10; i++) begin
      w[i] = {4'ha, 28'h0, 4'(i)};
      a_op(1'b1, 1'b1, 1'b0, w[i], v);
    end
    wait_bit(3, 1'b1);
    wait_bit(2, 1'b1);
    check(flg, 36'h3f);
    b_op(1'b0, 1'b0, 1'b0, 36'h0, v);
    check(v, w[0]);
    $display("fifo fill test done");
    replay_mode_sel <= 1'b1;
    for (i = 1; i < 4; i++) begin
      b_op(1'b1, 1'b0, 1'b0, 36'h0, v);
      check(v, w[i]);
    end
    replay_from_mark <= 1'b1;
    b_op(1'b0, 1'b0, 1'b0, 36'h0, v);
    replay_from_mark <= 1'b0;
    replay_mode_sel <= 1'b0;
    check(v, w[0]);
    for (i = 1; i < 10; i++) begin
      b_op(1'b1, 1'b0, 1'b0, 36'h0, v);
      check(v, w[i]);
    end
    check(flg, 36'h3b);
    b_op(1'b1, 1'b0, 1'b0, 36'h0, v);
    wait_bit(3, 1'b0);
    check(flg, 36'h33);
    $display("replay test done");
    resetn_i <= 1'b0;
    fs_hi <= 1'b1;
    fs_lo <= 1'b1;
    repeat (20) @(posedge clk_i);
    check(flg, 36'h23);
    resetn_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    for (i = 0; i < 22; i++) begin
      wait_fall(1'b0);
      if (i == 21) check(flg, 36'h23);
      fs_hi <= 1'b0;
      fs_lo <= ser_bits[21 - i];
    end
    wait_fall(1'b0);
    fs_hi <= 1'b1;
    wait_bit(4, 1'b1);
    check(flg, 36'h33);
    a_op(1'b1, 1'b1, 1'b0, 36'h0000000c1, v);
    a_op(1'b1, 1'b1, 1'b0, 36'h0000000c2, v);
    wait_bit(3, 1'b1);
    repeat (20) @(posedge clk_i);
    check(flg, 36'h3b);
    a_op(1'b1, 1'b1, 1'b0, 36'h0000000c3, v);
    wait_bit(2, 1'b1);
    check(flg, 36'h3f);
    $display("serial offset test done");
    complete_run();
  end
endmodule // tb_dcfm_ctl
